// ==== src/jsac_pkg.sv ====
// package of constants for the jtag security access control block
`default_nettype none
package jsac_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFF_PIN_ENABLE = 8'h00;
   localparam logic [7:0] OFF_NV_CONFIG  = 8'h04;
   localparam logic [7:0] OFF_STATUS     = 8'h08;
   localparam logic [7:0] OFF_CMD        = 8'h0C;
   localparam logic [7:0] OFF_RESULT     = 8'h10;
   // field positions
   localparam int BIT_PIN_ENABLE   = 0;
   localparam int BIT_NV_SECURE    = 0;
   localparam int BIT_NV_DEDICATE  = 1;
   localparam int BIT_NV_PROT_LSB  = 8;
   // reset values
   localparam logic [7:0]  PIN_ENABLE_RST = 8'h00;
   localparam logic [7:0]  CFG_BLANK      = 8'h00;
   localparam logic [31:0] DATA_BLANK     = 32'hFFFFFFFF;
   // sector counts
   localparam int PRI_SECTORS = 8;
   localparam int SEC_SECTORS = 4;
   localparam int ALL_SECTORS = PRI_SECTORS + SEC_SECTORS;
   // command codes over the jtag command port
   typedef enum logic [2:0] {
      JSAC_CMD_READ    = 3'h0,
      JSAC_CMD_PROGRAM = 3'h1,
      JSAC_CMD_SECT_ER = 3'h2,
      JSAC_CMD_VERIFY  = 3'h3,
      JSAC_CMD_CHIP_ER = 3'h4
   } jsac_cmd_t;
endpackage : jsac_pkg
`default_nettype wire

// ==== src/jsac_sector_guard.sv ====
// per-sector erase guard: one generate lane per sector
`default_nettype none
module jsac_sector_guard #(
   parameter int SECTORS = jsac_pkg::ALL_SECTORS
) (
   input  wire logic [SECTORS-1:0] protect_in,
   input  wire logic [3:0]         sector_in,
   output logic                    blocked_out
);
   logic [SECTORS-1:0] hit;
   // each lane flags a protected sector that is being addressed
   genvar g;
   generate
      for (g = 0; g < SECTORS; g++) begin : g_lane
         assign hit[g] = protect_in[g] && (sector_in == 4'(g));
      end
   endgenerate
   // out-of-range sector numbers are blocked too
   assign blocked_out = (|hit) || (sector_in >= 4'(SECTORS));
endmodule : jsac_sector_guard
`default_nettype wire

// ==== src/jsac_top.sv ====
// jtag security access control: enable, security and protect gating
//
// Contract
// - security set: refuse any memory readout, programmer or jtag.
// - security set: jtag accepts only the full chip erase command.
// - security set: other program, erase, verify commands rejected.
// - full chip erase clears security, leaves device blank and unsecured.
// - each primary and secondary sector protect bit blocks its erasure.
// - blank state: memory and logic array bits read as one.
// - blank state: all configuration register bits hold zero.
// - enable register bit 0 turns pins on; bits 1 to 7 unused.
// - pins dedicated by nonvolatile bit: reset neither aborts nor blocks.
// - pins enabled by register only: reset aborts and blocks jtag.
// - pins active if dedicate bit, register bit or product term.
// - device reset clears enable bit; host may clear it by write.
// - no enable source true: four pins released to port i/o.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
module jsac_top #(
   parameter int SECTORS = jsac_pkg::ALL_SECTORS
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // ahb-lite slave
   input  wire logic        hsel_in,
   input  wire logic [7:0]  haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // device reset and enable sources
   input  wire logic        dev_reset_in,
   input  wire logic        product_term_pin_select_in,
   // decoded jtag command stream
   input  wire logic        cmd_valid_in,
   input  wire logic [2:0]  cmd_op_in,
   input  wire logic [3:0]  cmd_sector_in,
   input  wire logic        prog_read_in,
   output logic             cmd_done_out,
   output logic             cmd_reject_out,
   output logic [31:0]      read_data_out,
   output logic             pins_jtag_out,
   output logic             secure_out
);
   // nonvolatile state: security, dedicate, sector protect
   logic               secure_r, secure_nxt;
   logic               dedic_r, dedic_nxt;
   logic [SECTORS-1:0] prot_r, prot_nxt;
   logic               pin_en_r, pin_en_nxt;
   logic [SECTORS-1:0] erased_r, erased_nxt;
   logic               done_r, done_nxt;
   logic               rej_r, rej_nxt;
   logic [31:0]        rdat_r, rdat_nxt;
   logic               pins_r, pins_nxt;
   logic [31:0]        hrdata_r, hrdata_nxt;
   logic               wr_pend_r, wr_pend_nxt;
   logic [7:0]         wr_addr_r, wr_addr_nxt;
   logic               sect_blocked;
   logic               jtag_live;
   logic               bus_req;
   logic               cmd_ok;

   jsac_sector_guard #(.SECTORS(SECTORS)) u_guard (
      .protect_in  (prot_r),
      .sector_in   (cmd_sector_in),
      .blocked_out (sect_blocked)
   );

   // register-only enable is killed by device reset; dedicate is not
   assign jtag_live = pins_r && (dedic_r || !dev_reset_in);
   assign bus_req   = hsel_in && hready_in && htrans_in[1];
   // stored secure bit is sampled before any command is allowed
   assign cmd_ok    = cmd_valid_in && jtag_live
                      && (!secure_r
                          || cmd_op_in == 3'(jsac_pkg::JSAC_CMD_CHIP_ER));

   // command and protection next state
   always_comb begin
      secure_nxt = secure_r;
      dedic_nxt  = dedic_r;
      prot_nxt   = prot_r;
      erased_nxt = erased_r;
      done_nxt   = 1'b0;
      rej_nxt    = 1'b0;
      rdat_nxt   = rdat_r;
      if (cmd_valid_in) begin
         if (!cmd_ok) begin
            rej_nxt = 1'b1;
         end else begin
            case (cmd_op_in)
               3'(jsac_pkg::JSAC_CMD_CHIP_ER): begin
                  secure_nxt = 1'b0;
                  erased_nxt = '1;
                  prot_nxt   = '0;
                  dedic_nxt  = 1'b0;
                  done_nxt   = 1'b1;
               end
               3'(jsac_pkg::JSAC_CMD_SECT_ER): begin
                  if (sect_blocked) begin
                     rej_nxt = 1'b1;
                  end else begin
                     erased_nxt[cmd_sector_in] = 1'b1;
                     done_nxt = 1'b1;
                  end
               end
               3'(jsac_pkg::JSAC_CMD_READ),
               3'(jsac_pkg::JSAC_CMD_VERIFY): begin
                  rdat_nxt = jsac_pkg::DATA_BLANK;
                  done_nxt = 1'b1;
               end
               3'(jsac_pkg::JSAC_CMD_PROGRAM): begin
                  if (cmd_sector_in < 4'(SECTORS)) begin
                     erased_nxt[cmd_sector_in] = 1'b0;
                  end
                  done_nxt = 1'b1;
               end
               default: rej_nxt = 1'b1;
            endcase
         end
      end
      // a device programmer read returns all zeros while secure, all ones otherwise
      if (prog_read_in) begin
         rdat_nxt = secure_r ? 32'h00000000 : jsac_pkg::DATA_BLANK;
      end
      // host writes the nonvolatile image over the bus
      if (wr_pend_r && wr_addr_r == jsac_pkg::OFF_NV_CONFIG) begin
         secure_nxt = hwdata_in[jsac_pkg::BIT_NV_SECURE];
         dedic_nxt  = hwdata_in[jsac_pkg::BIT_NV_DEDICATE];
         prot_nxt   = hwdata_in[jsac_pkg::BIT_NV_PROT_LSB +: SECTORS];
      end
      if (secure_r && !cmd_ok && cmd_valid_in) begin
         rdat_nxt = 32'h00000000;
      end
   end

   // enable register and pin routing next state
   always_comb begin
      pin_en_nxt = pin_en_r;
      if (dev_reset_in) begin
         pin_en_nxt = 1'b0;
      end else if (wr_pend_r && wr_addr_r == jsac_pkg::OFF_PIN_ENABLE) begin
         pin_en_nxt = hwdata_in[jsac_pkg::BIT_PIN_ENABLE];
      end
      // any source grants the pins, else they return to port i/o
      pins_nxt = dedic_r || pin_en_r
                 || product_term_pin_select_in;
   end

   // ahb-lite slave: zero wait, always okay
   always_comb begin
      // sub-word writes are dropped: every register is one whole word
      wr_pend_nxt = bus_req && hwrite_in && hsize_in == 3'h2;
      wr_addr_nxt = bus_req ? haddr_in : wr_addr_r;
      hrdata_nxt  = hrdata_r;
      if (bus_req && !hwrite_in) begin
         case (haddr_in)
            jsac_pkg::OFF_PIN_ENABLE: hrdata_nxt = {31'h0, pin_en_nxt};
            jsac_pkg::OFF_NV_CONFIG:
               hrdata_nxt = {{(24-SECTORS){1'b0}}, prot_r, 6'h00,
                             dedic_r, secure_r};
            jsac_pkg::OFF_STATUS:
               hrdata_nxt = {28'h0, jtag_live, pins_r, rej_r, done_r};
            jsac_pkg::OFF_RESULT: hrdata_nxt = rdat_r;
            default:              hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   // registers: nonvolatile bits reset to the blank image
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         secure_r  <= 1'b0;
         dedic_r   <= 1'b0;
         prot_r    <= '0;
         erased_r  <= '1;
         pin_en_r  <= 1'b0;
         done_r    <= 1'b0;
         rej_r     <= 1'b0;
         rdat_r    <= jsac_pkg::DATA_BLANK;
         pins_r    <= 1'b0;
         hrdata_r  <= 32'h00000000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         secure_r  <= secure_nxt;
         dedic_r   <= dedic_nxt;
         prot_r    <= prot_nxt;
         erased_r  <= erased_nxt;
         pin_en_r  <= pin_en_nxt;
         done_r    <= done_nxt;
         rej_r     <= rej_nxt;
         rdat_r    <= rdat_nxt;
         pins_r    <= pins_nxt;
         hrdata_r  <= hrdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
      end
   end

   assign hrdata_out     = hrdata_r;
   assign hreadyout_out  = 1'b1;
   assign hresp_out      = 1'b0;
   assign cmd_done_out   = done_r;
   assign cmd_reject_out = rej_r;
   assign read_data_out  = rdat_r;
   assign pins_jtag_out  = pins_r;
   assign secure_out     = secure_r;

   // checks: each one but a_secure_hold guards a single rule of the contract above
   a_secure_reject: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && secure_r
      && cmd_op_in != 3'(jsac_pkg::JSAC_CMD_CHIP_ER) |=> rej_r && !done_r)
      else $error("secure command not rejected");
   a_secure_effect: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && secure_r && !wr_pend_r
      && cmd_op_in != 3'(jsac_pkg::JSAC_CMD_CHIP_ER)
      |=> $stable(erased_r) && $stable(prot_r))
      else $error("secure command had an effect");
   a_secure_noread: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      secure_r && cmd_valid_in && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_READ)
      |=> rdat_r == 32'h00000000)
      else $error("read leaked while secure");
   a_prog_secure: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      prog_read_in && secure_r |=> rdat_r == 32'h00000000)
      else $error("programmer read leaked while secure");
   a_prog_blank: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      prog_read_in && !secure_r |=> rdat_r == jsac_pkg::DATA_BLANK)
      else $error("blank programmer read not all ones");
   a_blank_read: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && cmd_ok
      && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_READ)
      |=> rdat_r == jsac_pkg::DATA_BLANK && done_r)
      else $error("blank jtag read not all ones");
   a_chip_erase_clr: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && jtag_live && !wr_pend_r
      && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_CHIP_ER)
      |=> !secure_r && done_r && &erased_r)
      else $error("chip erase left device secured");
   a_erase_cfg: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && jtag_live && !wr_pend_r
      && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_CHIP_ER)
      |=> prot_r == '0 && !dedic_r)
      else $error("chip erase left configuration bits set");
   a_prot_block: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_in && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_SECT_ER)
      && sect_blocked |=> rej_r && $stable(erased_r))
      else $error("protected sector erased");
   a_only_erase: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      secure_r && cmd_valid_in
      |=> done_r == ($past(cmd_op_in) == 3'(jsac_pkg::JSAC_CMD_CHIP_ER)
                     && $past(jtag_live)))
      else $error("non erase command done while secure");
   a_secure_hold: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !cmd_valid_in && !wr_pend_r |=> $stable(secure_r) && $stable(prot_r))
      else $error("nonvolatile bits changed with no command");
   a_reset_clears: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      dev_reset_in |=> !pin_en_r)
      else $error("device reset did not clear enable");
   a_pins_release: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !dedic_r && !pin_en_r && !product_term_pin_select_in |=> !pins_r)
      else $error("pins not released");
   a_pins_any: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      dedic_r || pin_en_r || product_term_pin_select_in |=> pins_r)
      else $error("pins not granted");
   a_reset_abort: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      dev_reset_in && !dedic_r && cmd_valid_in |=> rej_r)
      else $error("reset did not block jtag");
   a_dedic_survive: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      dev_reset_in && dedic_r && pins_r && cmd_valid_in && !secure_r
      && cmd_op_in == 3'(jsac_pkg::JSAC_CMD_VERIFY) |=> done_r)
      else $error("reset blocked dedicated jtag");
   a_enable_write: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wr_pend_r && wr_addr_r == jsac_pkg::OFF_PIN_ENABLE && !dev_reset_in
      |=> pin_en_r == $past(hwdata_in[0]))
      else $error("enable write lost");
   // main scenarios that the bench is expected to reach
   c_chip_erase: cover property (@(posedge clk_in)
      secure_r ##1 !secure_r);
   c_prot_reject: cover property (@(posedge clk_in)
      cmd_valid_in && sect_blocked && cmd_op_in == 3'h2);
   c_reset_abort: cover property (@(posedge clk_in)
      dev_reset_in && cmd_valid_in && !dedic_r);
   c_dedic_survive: cover property (@(posedge clk_in)
      dev_reset_in && cmd_valid_in && dedic_r);
   c_prog_secure: cover property (@(posedge clk_in)
      prog_read_in && secure_r);
endmodule : jsac_top
`default_nettype wire

// ==== bench/jsac_jtag_host.sv ====
// model of the external jtag programmer feeding decoded commands
`default_nettype none
module jsac_jtag_host (
   input  wire logic       clk_in,
   input  wire logic       done_in,
   input  wire logic       reject_in,
   output logic            cmd_valid_out,
   output logic [2:0]      cmd_op_out,
   output logic [3:0]      cmd_sector_out,
   output logic            prog_read_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle request lines from time zero
   initial begin
      cmd_valid_out = 1'b0;
      cmd_op_out = 3'h0;
      cmd_sector_out = 4'h0;
      prog_read_out = 1'b0;
   end
   // one-cycle command pulse, answer sampled while it stands
   task automatic issue(input logic [2:0] op, input logic [3:0] sec,
                        output logic d, output logic r);
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_op_out <= op;
      cmd_sector_out <= sec;
      @(posedge clk_in);
      cmd_valid_out <= 1'b0;
      // done or reject stands one cycle only
      @(posedge clk_in);
      d = done_in;
      r = reject_in;
   endtask : issue
   // device programmer readout pulse
   task automatic prog_pulse();
      @(posedge clk_in);
      prog_read_out <= 1'b1;
      @(posedge clk_in);
      prog_read_out <= 1'b0;
      @(posedge clk_in);
   endtask : prog_pulse
endmodule : jsac_jtag_host
`default_nettype wire

// ==== bench/tb_jtag_security_access_control.sv ====
// self-checking bench for the jtag security access control block
`default_nettype none
module tb_jtag_security_access_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, hsel, hwrite, hready, hresp, dev_reset, pt_sel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize, cmd_op;
   logic [31:0] hwdata, hrdata, rdata;
   logic        cmd_valid, prog_read, done, reject, pins, secure;
   logic [3:0]  cmd_sector;
   int          errors, total_checks;

   jsac_top uut (.clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .dev_reset_in(dev_reset), .product_term_pin_select_in(pt_sel),
      .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
      .cmd_sector_in(cmd_sector), .prog_read_in(prog_read),
      .cmd_done_out(done), .cmd_reject_out(reject),
      .read_data_out(rdata), .pins_jtag_out(pins), .secure_out(secure));
   jsac_jtag_host host (.clk_in(clk), .done_in(done), .reject_in(reject),
      .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
      .cmd_sector_out(cmd_sector), .prog_read_out(prog_read));

   // 40 mhz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // bounded wait for hready at a rising edge; a hang ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         chk("hready", {31'h0, hready}, 32'h1);
         tally_and_finish();
      end
   endtask : wait_ready
   // single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic rd(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(n, x, e);
   endtask : rd
   task automatic cmd(input string n, input logic [2:0] op,
                      input logic [3:0] s, input logic ed, er);
      logic d, r;
      host.issue(op, s, d, r);
      chk({n, " done"}, {31'h0, d}, {31'h0, ed});
      chk({n, " reject"}, {31'h0, r}, {31'h0, er});
   endtask : cmd
   // registered outputs need a few edges after a write
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle

   // main sequence; bus map writes go through word transfers only
   initial begin
      errors = 0;
      total_checks = 0;
      rst_n = 1'b0;
      {hsel, hwrite, dev_reset, pt_sel} = 4'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (5) @(posedge clk);
      chk("secure at reset", {31'h0, secure}, 32'h0);
      chk("blank read data", rdata, 32'hFFFFFFFF);
      rst_n <= 1'b1;
      @(posedge clk);
      rd("pin enable", jsac_pkg::OFF_PIN_ENABLE, 32'h0);
      rd("nv image", jsac_pkg::OFF_NV_CONFIG, 32'h0);
      rd("reserved", jsac_pkg::OFF_CMD, 32'h0);
      chk("bus response", {31'h0, hresp}, 32'h0);
      chk("pins idle", {31'h0, pins}, 32'h0);
      cmd("no source read", 3'h0, 4'h0, 1'b0, 1'b1);
      $display("test reset state done");
      // enable register and product term sources
      wr(jsac_pkg::OFF_PIN_ENABLE, 32'h00000001);
      settle();
      chk("pins by register", {31'h0, pins}, 32'h1);
      cmd("blank read", 3'h0, 4'h0, 1'b1, 1'b0);
      chk("blank data", rdata, 32'hFFFFFFFF);
      wr(jsac_pkg::OFF_PIN_ENABLE, 32'h00000000);
      settle();
      chk("pins cleared", {31'h0, pins}, 32'h0);
      pt_sel <= 1'b1;
      settle();
      chk("pins by term", {31'h0, pins}, 32'h1);
      pt_sel <= 1'b0;
      settle();
      chk("pins released", {31'h0, pins}, 32'h0);
      $display("test enable sources done");
      // dedicated pins, sector 9 protected
      wr(jsac_pkg::OFF_NV_CONFIG, 32'h00020002);
      cmd("erase protected", 3'h2, 4'h9, 1'b0, 1'b1);
      cmd("erase open", 3'h2, 4'h3, 1'b1, 1'b0);
      cmd("erase past end", 3'h2, 4'hC, 1'b0, 1'b1);
      dev_reset <= 1'b1;
      cmd("dedicated in reset", 3'h3, 4'h0, 1'b1, 1'b0);
      dev_reset <= 1'b0;
      wr(jsac_pkg::OFF_NV_CONFIG, 32'h00000000);
      wr(jsac_pkg::OFF_PIN_ENABLE, 32'h00000001);
      settle();
      cmd("register only", 3'h1, 4'h0, 1'b1, 1'b0);
      dev_reset <= 1'b1;
      cmd("register in reset", 3'h1, 4'h0, 1'b0, 1'b1);
      dev_reset <= 1'b0;
      settle();
      rd("enable after reset", jsac_pkg::OFF_PIN_ENABLE, 32'h0);
      $display("test protect and reset done");
      // security bit set with dedicated pins; read data was all ones
      wr(jsac_pkg::OFF_NV_CONFIG, 32'h00000003);
      settle();
      chk("secure set", {31'h0, secure}, 32'h1);
      cmd("secured read", 3'h0, 4'h0, 1'b0, 1'b1);
      chk("secured data", rdata, 32'h00000000);
      for (int i = 0; i < 4; i++) begin
         cmd("secured op", 3'(i), 4'h1, 1'b0, 1'b1);
      end
      cmd("chip erase", 3'h4, 4'h0, 1'b1, 1'b0);
      chk("secure cleared", {31'h0, secure}, 32'h0);
      rd("nv blank", jsac_pkg::OFF_NV_CONFIG, 32'h0);
      host.prog_pulse();
      chk("programmer blank", rdata, 32'hFFFFFFFF);
      wr(jsac_pkg::OFF_PIN_ENABLE, 32'h00000001);
      settle();
      cmd("program after erase", 3'h1, 4'h2, 1'b1, 1'b0);
      // secure again: a programmer read must turn all ones into zero
      wr(jsac_pkg::OFF_NV_CONFIG, 32'h00000001);
      settle();
      host.prog_pulse();
      chk("programmer data", rdata, 32'h00000000);
      $display("test security done");
      tally_and_finish();
   end
endmodule : tb_jtag_security_access_control
`default_nettype wire
